/* rtl/abpf_pkg.sv */
package abpf_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [15:0] PORT2_BIT_CLOCK_RATE_ADDR   = 16'h0540;
  localparam logic [15:0] PORT2_TX_FRAME_DIVIDER_ADDR = 16'h0545;
  localparam logic [15:0] PORT2_RX_FRAME_DIVIDER_ADDR = 16'h0546;
  localparam logic [15:0] PORT3_BIT_CLOCK_RATE_ADDR   = 16'h0580;
  localparam logic [15:0] PORT3_TX_FRAME_DIVIDER_ADDR = 16'h0585;
  localparam logic [15:0] PORT3_RX_FRAME_DIVIDER_ADDR = 16'h0586;

  // ==========================================================================
  // Fields and reset values
  // ==========================================================================
  localparam int          RATE_CODE_LSB = 0;
  localparam int          RATE_CODE_W   = 5;
  localparam int          DIV_LSB       = 0;
  localparam int          DIV_W         = 13;
  localparam logic [4:0]  RATE_CODE_RST = 5'h0c;
  localparam logic [12:0] DIV_RST       = 13'h0040;
  localparam logic [4:0]  RATE_CODE_MIN = 5'h02;
  localparam logic [4:0]  RATE_CODE_MAX = 5'h12;

  // ==========================================================================
  // Clock domain and family selection
  // ==========================================================================
  localparam logic [3:0] ASYNC_SELECT_MIN = 4'h8;
  localparam int         FAMILY_MSB       = 4;
  localparam int         FAMILY_LSB       = 3;
  localparam logic [1:0] FAMILY_44K_CODE  = 2'h1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          SYS_CLK_PERIOD_NS = 4;
  localparam logic [63:0] SYS_CLK_HZ        = 64'(1000000000 / SYS_CLK_PERIOD_NS);
  localparam int          NCO_W             = 32;

  typedef enum logic [1:0] {
    ABPF_STOPPED,
    ABPF_MASTER,
    ABPF_SLAVE
  } abpf_state_t;

  // Bit-clock frequency in Hz of the 48 kHz family; zero for reserved codes.
  function automatic logic [63:0] abpf_freq_48k(input logic [4:0] code);
    logic [63:0] f;
    case (code)
      5'h02:   f = 64'd64000;
      5'h03:   f = 64'd96000;
      5'h04:   f = 64'd128000;
      5'h05:   f = 64'd192000;
      5'h06:   f = 64'd256000;
      5'h07:   f = 64'd384000;
      5'h08:   f = 64'd512000;
      5'h09:   f = 64'd768000;
      5'h0a:   f = 64'd1024000;
      5'h0b:   f = 64'd1536000;
      5'h0c:   f = 64'd2048000;
      5'h0d:   f = 64'd3072000;
      5'h0e:   f = 64'd4096000;
      5'h0f:   f = 64'd6144000;
      5'h10:   f = 64'd8192000;
      5'h11:   f = 64'd12288000;
      5'h12:   f = 64'd24576000;
      default: f = 64'd0;
    endcase
    return f;
  endfunction : abpf_freq_48k

  // Phase increment per system clock; the 44.1 kHz family is 147/160 of it.
  function automatic logic [NCO_W-1:0] abpf_incr(input logic [4:0] code,
                                                  input logic       fam44);
    logic [63:0] f;
    logic [63:0] q;
    f = abpf_freq_48k(code);
    if (fam44) begin
      f = (f * 64'd147) / 64'd160;
    end
    q = (f << 32) / SYS_CLK_HZ;
    return q[NCO_W-1:0];
  endfunction : abpf_incr

endpackage : abpf_pkg

/* rtl/abpf_cfg_if.sv */
`timescale 1ns/1ps
interface abpf_cfg_if;
  logic [4:0]  rate_code;
  logic [12:0] tx_div;
  logic [12:0] rx_div;

  modport store (output rate_code, output tx_div, output rx_div);
  modport sink (input rate_code, input tx_div, input rx_div);
endinterface : abpf_cfg_if

/* rtl/abpf_regs.sv */
`timescale 1ns/1ps
module abpf_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd_en,
  output logic      [15:0] reg_rdata,
  abpf_cfg_if.store        cfg2,
  abpf_cfg_if.store        cfg3
);

  // ==========================================================================
  // Writes
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cfg2.rate_code <= abpf_pkg::RATE_CODE_RST;
      cfg2.tx_div    <= abpf_pkg::DIV_RST;
      cfg2.rx_div    <= abpf_pkg::DIV_RST;
      cfg3.rate_code <= abpf_pkg::RATE_CODE_RST;
      cfg3.tx_div    <= abpf_pkg::DIV_RST;
      cfg3.rx_div    <= abpf_pkg::DIV_RST;
    end else if (ce && reg_wr_en) begin
      case (reg_addr)
        abpf_pkg::PORT2_BIT_CLOCK_RATE_ADDR:
          cfg2.rate_code <= reg_wdata[abpf_pkg::RATE_CODE_LSB +: abpf_pkg::RATE_CODE_W];
        abpf_pkg::PORT2_TX_FRAME_DIVIDER_ADDR:
          cfg2.tx_div <= reg_wdata[abpf_pkg::DIV_LSB +: abpf_pkg::DIV_W];
        abpf_pkg::PORT2_RX_FRAME_DIVIDER_ADDR:
          cfg2.rx_div <= reg_wdata[abpf_pkg::DIV_LSB +: abpf_pkg::DIV_W];
        abpf_pkg::PORT3_BIT_CLOCK_RATE_ADDR:
          cfg3.rate_code <= reg_wdata[abpf_pkg::RATE_CODE_LSB +: abpf_pkg::RATE_CODE_W];
        abpf_pkg::PORT3_TX_FRAME_DIVIDER_ADDR:
          cfg3.tx_div <= reg_wdata[abpf_pkg::DIV_LSB +: abpf_pkg::DIV_W];
        abpf_pkg::PORT3_RX_FRAME_DIVIDER_ADDR:
          cfg3.rx_div <= reg_wdata[abpf_pkg::DIV_LSB +: abpf_pkg::DIV_W];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Reads: one cycle of latency, unused bits and unmapped addresses read zero
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (ce && reg_rd_en) begin
      case (reg_addr)
        abpf_pkg::PORT2_BIT_CLOCK_RATE_ADDR:   reg_rdata <= {11'h000, cfg2.rate_code};
        abpf_pkg::PORT2_TX_FRAME_DIVIDER_ADDR: reg_rdata <= {3'h0, cfg2.tx_div};
        abpf_pkg::PORT2_RX_FRAME_DIVIDER_ADDR: reg_rdata <= {3'h0, cfg2.rx_div};
        abpf_pkg::PORT3_BIT_CLOCK_RATE_ADDR:   reg_rdata <= {11'h000, cfg3.rate_code};
        abpf_pkg::PORT3_TX_FRAME_DIVIDER_ADDR: reg_rdata <= {3'h0, cfg3.tx_div};
        abpf_pkg::PORT3_RX_FRAME_DIVIDER_ADDR: reg_rdata <= {3'h0, cfg3.rx_div};
        default:                               reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule : abpf_regs

/* rtl/abpf_frame_div.sv */
`timescale 1ns/1ps
module abpf_frame_div (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic [12:0] div,
  output logic             frame_clk
);

  logic [12:0] count;
  logic [13:0] next_count_wide;
  logic [12:0] next_count;
  logic [13:0] half;

  // Counts bit-clock falling edges; the frame is high for its first half.
  always_comb begin
    next_count_wide = {1'b0, count} + 14'h0001;
    if (next_count_wide >= {1'b0, div}) begin
      next_count = 13'h0000;
    end else begin
      next_count = next_count_wide[12:0];
    end
    half = ({1'b0, div} + 14'h0001) >> 1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count     <= 13'h0000;
      frame_clk <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        count     <= 13'h0000;
        frame_clk <= 1'b0;
      end else if (tick) begin
        count     <= next_count;
        frame_clk <= ({1'b0, next_count} < half);
      end
    end
  end

endmodule : abpf_frame_div

/* rtl/abpf_top.sv */
`timescale 1ns/1ps
module abpf_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd_en,
  output logic      [15:0] reg_rdata,
  input  wire logic [3:0]  port2_rate_select,
  input  wire logic [3:0]  port3_rate_select,
  input  wire logic [4:0]  sys_sample_rate_setting,
  input  wire logic [4:0]  async_sample_rate_setting,
  input  wire logic        port2_master,
  input  wire logic        port3_master,
  input  wire logic        port2_tx_frame_source_select,
  input  wire logic        port3_tx_frame_source_select,
  input  wire logic        port2_bit_clock_i,
  output logic             port2_bit_clock_o,
  output logic             port2_bit_clock_oe,
  input  wire logic        port2_rx_frame_clock_i,
  output logic             port2_rx_frame_clock_o,
  output logic             port2_rx_frame_clock_oe,
  input  wire logic        port2_tx_frame_clock_i,
  output logic             port2_tx_frame_clock_o,
  output logic             port2_tx_frame_clock_oe,
  output logic             port2_rx_frame_sync,
  output logic             port2_tx_frame_sync,
  output logic             port2_async_domain,
  output logic             port2_family_44k,
  input  wire logic        port3_bit_clock_i,
  output logic             port3_bit_clock_o,
  output logic             port3_bit_clock_oe,
  input  wire logic        port3_rx_frame_clock_i,
  output logic             port3_rx_frame_clock_o,
  output logic             port3_rx_frame_clock_oe,
  input  wire logic        port3_tx_frame_clock_i,
  output logic             port3_tx_frame_clock_o,
  output logic             port3_tx_frame_clock_oe,
  output logic             port3_rx_frame_sync,
  output logic             port3_tx_frame_sync,
  output logic             port3_async_domain,
  output logic             port3_family_44k
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  abpf_cfg_if cfg2 ();
  abpf_cfg_if cfg3 ();

  abpf_regs u_regs (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .reg_addr  (reg_addr),
    .reg_wr_en (reg_wr_en),
    .reg_wdata (reg_wdata),
    .reg_rd_en (reg_rd_en),
    .reg_rdata (reg_rdata),
    .cfg2      (cfg2.store),
    .cfg3      (cfg3.store)
  );

  // ==========================================================================
  // Per-port views
  // ==========================================================================
  logic [4:0]  rate_code   [2];
  logic [12:0] tx_div      [2];
  logic [12:0] rx_div      [2];
  logic [3:0]  rate_select [2];
  logic        master      [2];
  logic        tx_src      [2];
  logic        bclk_in     [2];
  logic        rx_lr_in    [2];
  logic        tx_lr_in    [2];

  logic        bclk_q      [2];
  logic        bclk_oe_q   [2];
  logic        rx_lr_q     [2];
  logic        rx_lr_oe_q  [2];
  logic        tx_lr_q     [2];
  logic        tx_lr_oe_q  [2];
  logic        rx_sync_q   [2];
  logic        tx_sync_q   [2];
  logic        async_q     [2];
  logic        fam44_q     [2];

  assign rate_code[0]   = cfg2.rate_code;
  assign rate_code[1]   = cfg3.rate_code;
  assign tx_div[0]      = cfg2.tx_div;
  assign tx_div[1]      = cfg3.tx_div;
  assign rx_div[0]      = cfg2.rx_div;
  assign rx_div[1]      = cfg3.rx_div;
  assign rate_select[0] = port2_rate_select;
  assign rate_select[1] = port3_rate_select;
  assign master[0]      = port2_master;
  assign master[1]      = port3_master;
  assign tx_src[0]      = port2_tx_frame_source_select;
  assign tx_src[1]      = port3_tx_frame_source_select;
  assign bclk_in[0]     = port2_bit_clock_i;
  assign bclk_in[1]     = port3_bit_clock_i;
  assign rx_lr_in[0]    = port2_rx_frame_clock_i;
  assign rx_lr_in[1]    = port3_rx_frame_clock_i;
  assign tx_lr_in[0]    = port2_tx_frame_clock_i;
  assign tx_lr_in[1]    = port3_tx_frame_clock_i;

  // ==========================================================================
  // Port clock generation
  // ==========================================================================
  for (genvar p = 0; p < 2; p++) begin : g_port
    abpf_pkg::abpf_state_t      st;
    abpf_pkg::abpf_state_t      next_st;
    logic [abpf_pkg::NCO_W-1:0] acc;
    logic [abpf_pkg::NCO_W-1:0] next_acc;
    logic                       code_ok;
    logic                       is_async;
    logic                       is_44k;
    logic                       run;
    logic                       tick;
    logic                       rx_frame;
    logic                       tx_frame;

    always_comb begin
      code_ok = (rate_code[p] >= abpf_pkg::RATE_CODE_MIN)
             && (rate_code[p] <= abpf_pkg::RATE_CODE_MAX);
      is_async = (rate_select[p] >= abpf_pkg::ASYNC_SELECT_MIN);
      if (is_async) begin
        is_44k = (async_sample_rate_setting[abpf_pkg::FAMILY_MSB:abpf_pkg::FAMILY_LSB]
                  == abpf_pkg::FAMILY_44K_CODE);
      end else begin
        is_44k = (sys_sample_rate_setting[abpf_pkg::FAMILY_MSB:abpf_pkg::FAMILY_LSB]
                  == abpf_pkg::FAMILY_44K_CODE);
      end
    end

    // Reserved codes stop the master clocks rather than run at a guess.
    always_comb begin
      case (st)
        abpf_pkg::ABPF_STOPPED: begin
          if (!master[p]) begin
            next_st = abpf_pkg::ABPF_SLAVE;
          end else if (code_ok) begin
            next_st = abpf_pkg::ABPF_MASTER;
          end else begin
            next_st = abpf_pkg::ABPF_STOPPED;
          end
        end
        abpf_pkg::ABPF_MASTER: begin
          if (!master[p]) begin
            next_st = abpf_pkg::ABPF_SLAVE;
          end else if (!code_ok) begin
            next_st = abpf_pkg::ABPF_STOPPED;
          end else begin
            next_st = abpf_pkg::ABPF_MASTER;
          end
        end
        abpf_pkg::ABPF_SLAVE: begin
          if (!master[p]) begin
            next_st = abpf_pkg::ABPF_SLAVE;
          end else if (code_ok) begin
            next_st = abpf_pkg::ABPF_MASTER;
          end else begin
            next_st = abpf_pkg::ABPF_STOPPED;
          end
        end
        default: next_st = abpf_pkg::ABPF_STOPPED;
      endcase
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        st <= abpf_pkg::ABPF_STOPPED;
      end else if (ce) begin
        st <= next_st;
      end
    end

    // The bit clock is the top bit of a phase accumulator; the increment
    // stays below half a turn only while the rate is below half the clock.
    assign run      = (st == abpf_pkg::ABPF_MASTER);
    assign next_acc = acc + abpf_pkg::abpf_incr(rate_code[p], is_44k);
    assign tick     = run && acc[abpf_pkg::NCO_W-1] && !next_acc[abpf_pkg::NCO_W-1];

    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        acc    <= '0;
        bclk_q[p] <= 1'b0;
      end else if (ce) begin
        if (run) begin
          acc       <= next_acc;
          bclk_q[p] <= next_acc[abpf_pkg::NCO_W-1];
        end else begin
          acc       <= '0;
          bclk_q[p] <= 1'b0;
        end
      end
    end

    abpf_frame_div u_rx_div (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .ce        (ce),
      .run       (run),
      .tick      (tick),
      .div       (rx_div[p]),
      .frame_clk (rx_frame)
    );

    abpf_frame_div u_tx_div (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .ce        (ce),
      .run       (run),
      .tick      (tick),
      .div       (tx_div[p]),
      .frame_clk (tx_frame)
    );

    // Pin drive and frame synchronisation toward the data paths.
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        bclk_oe_q[p]  <= 1'b0;
        rx_lr_q[p]    <= 1'b0;
        rx_lr_oe_q[p] <= 1'b0;
        tx_lr_q[p]    <= 1'b0;
        tx_lr_oe_q[p] <= 1'b0;
        rx_sync_q[p]  <= 1'b0;
        tx_sync_q[p]  <= 1'b0;
        async_q[p]    <= 1'b0;
        fam44_q[p]    <= 1'b0;
      end else if (ce) begin
        bclk_oe_q[p]  <= run;
        rx_lr_q[p]    <= rx_frame;
        rx_lr_oe_q[p] <= run;
        tx_lr_q[p]    <= tx_frame;
        tx_lr_oe_q[p] <= run && tx_src[p];
        async_q[p]    <= is_async;
        fam44_q[p]    <= is_44k;
        if (run) begin
          rx_sync_q[p] <= rx_frame;
          tx_sync_q[p] <= tx_src[p] ? tx_frame : rx_frame;
        end else begin
          rx_sync_q[p] <= rx_lr_in[p];
          tx_sync_q[p] <= tx_src[p] ? tx_lr_in[p] : rx_lr_in[p];
        end
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign port2_bit_clock_o       = bclk_q[0];
  assign port2_bit_clock_oe      = bclk_oe_q[0];
  assign port2_rx_frame_clock_o  = rx_lr_q[0];
  assign port2_rx_frame_clock_oe = rx_lr_oe_q[0];
  assign port2_tx_frame_clock_o  = tx_lr_q[0];
  assign port2_tx_frame_clock_oe = tx_lr_oe_q[0];
  assign port2_rx_frame_sync     = rx_sync_q[0];
  assign port2_tx_frame_sync     = tx_sync_q[0];
  assign port2_async_domain      = async_q[0];
  assign port2_family_44k        = fam44_q[0];
  assign port3_bit_clock_o       = bclk_q[1];
  assign port3_bit_clock_oe      = bclk_oe_q[1];
  assign port3_rx_frame_clock_o  = rx_lr_q[1];
  assign port3_rx_frame_clock_oe = rx_lr_oe_q[1];
  assign port3_tx_frame_clock_o  = tx_lr_q[1];
  assign port3_tx_frame_clock_oe = tx_lr_oe_q[1];
  assign port3_rx_frame_sync     = rx_sync_q[1];
  assign port3_tx_frame_sync     = tx_sync_q[1];
  assign port3_async_domain      = async_q[1];
  assign port3_family_44k        = fam44_q[1];

endmodule : abpf_top

/* testbench/abpf_far_end.sv */
`timescale 1ns/1ps
// ==========================================================
// Far-end port that sources bit and frame clocks to a slave.
module abpf_far_end (
  input  wire logic        sys_clk,
  input  wire logic        en,
  input  wire logic [12:0] div,
  output logic             bclk,
  output logic             frame
);
  logic [1:0]  ph;
  logic [12:0] cnt;
  logic [12:0] next_cnt;

  assign next_cnt = (cnt + 13'h1 >= div) ? 13'h0 : cnt + 13'h1;
  always_ff @(posedge sys_clk) begin
    if (!en) begin
      ph    <= 2'h0;
      bclk  <= 1'h0;
      cnt   <= 13'h0;
      frame <= 1'h0;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2) begin
        bclk <= !bclk;
        if (bclk) begin
          cnt   <= next_cnt;
          frame <= next_cnt < div / 13'h2;
        end
      end
    end
  end
endmodule : abpf_far_end

/* testbench/abpf_top_sva.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checks on the clock generator.
module abpf_top_sva (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        reg_rd_en,
  input wire logic [15:0] reg_rdata,
  input wire logic [3:0]  port2_rate_select,
  input wire logic [4:0]  sys_sample_rate_setting,
  input wire logic [4:0]  async_sample_rate_setting,
  input wire logic        port2_master,
  input wire logic        port2_tx_frame_source_select,
  input wire logic        port2_rx_frame_clock_i,
  input wire logic        port2_bit_clock_o,
  input wire logic        port2_bit_clock_oe,
  input wire logic        port2_rx_frame_clock_o,
  input wire logic        port2_rx_frame_clock_oe,
  input wire logic        port2_tx_frame_clock_oe,
  input wire logic        port2_rx_frame_sync,
  input wire logic        port2_tx_frame_sync,
  input wire logic        port2_async_domain,
  input wire logic        port2_family_44k,
  input wire logic        port3_bit_clock_oe
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_sys_family: assert property (
    $past(rst_b) && port2_bit_clock_oe && !port2_rate_select[3] && $stable(port2_rate_select)
    && $stable(sys_sample_rate_setting) |-> !port2_async_domain
    && port2_family_44k == (sys_sample_rate_setting[4:3] == 2'h1))
    else $error("bad system family");
  a_async_family: assert property (
    $past(rst_b) && port2_bit_clock_oe && port2_rate_select[3] && $stable(port2_rate_select)
    && $stable(async_sample_rate_setting) |-> port2_async_domain
    && port2_family_44k == (async_sample_rate_setting[4:3] == 2'h1))
    else $error("bad async family");
  a_tx_on_rx: assert property (
    !port2_tx_frame_source_select [*3] |-> port2_tx_frame_sync == port2_rx_frame_sync
    && !port2_tx_frame_clock_oe)
    else $error("tx not on rx frame");
  a_tx_oe_master: assert property (
    port2_tx_frame_clock_oe |-> port2_bit_clock_oe)
    else $error("tx frame pin without bit clock");
  a_slave_quiet: assert property (
    !port2_master [*3] |-> !port2_bit_clock_oe && !port2_rx_frame_clock_oe
    && port2_rx_frame_sync == $past(port2_rx_frame_clock_i))
    else $error("bad slave port");
  a_frame_on_fall: assert property (
    port2_bit_clock_o [*3] |-> $stable(port2_rx_frame_clock_o))
    else $error("frame moved with bit clock high");
  a_reset_quiet: assert property (
    disable iff (1'h0) !rst_b |=> reg_rdata == 16'h0 && !port2_bit_clock_oe
    && !port3_bit_clock_oe)
    else $error("outputs active in reset");
  a_read_width: assert property (
    $past(reg_rd_en) |-> reg_rdata[15:13] == 3'h0)
    else $error("read data too wide");

  c_master: cover property (port2_bit_clock_oe && port2_tx_frame_clock_oe);
  c_family: cover property (port2_family_44k && port2_async_domain);
  c_slave: cover property (!port2_master && port2_rx_frame_sync);
endmodule : abpf_top_sva

bind abpf_top abpf_top_sva chk_u (.*);

/* testbench/test_audio_port_bit_frame_clock_gen.sv */
`timescale 1ns/1ps
// ==========================================================
// Bench for the port bit and frame clock generator.
module test_audio_port_bit_frame_clock_gen;
  localparam logic [15:0] RA [6] = '{16'h0540, 16'h0545, 16'h0546, 16'h0580, 16'h0585, 16'h0586};
  logic        sys_clk;
  logic        rst_b = 1'h0;
  logic        ce = 1'h1;
  logic [15:0] reg_addr = 16'h0;
  logic        reg_wr_en = 1'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic        reg_rd_en = 1'h0;
  logic [15:0] reg_rdata;
  logic [3:0]  port2_rate_select = 4'h0;
  logic [3:0]  port3_rate_select = 4'h8;
  logic [4:0]  sys_sample_rate_setting = 5'h0;
  logic [4:0]  async_sample_rate_setting = 5'h0;
  logic        port2_master = 1'h1;
  logic        port3_master = 1'h1;
  logic        port2_tx_frame_source_select = 1'h0;
  logic        port3_tx_frame_source_select = 1'h1;
  logic        port2_bit_clock_o, port2_bit_clock_oe, port2_rx_frame_clock_o;
  logic        port2_rx_frame_clock_oe, port2_tx_frame_clock_o, port2_tx_frame_clock_oe;
  logic        port2_rx_frame_sync, port2_tx_frame_sync, port2_async_domain, port2_family_44k;
  logic        port3_bit_clock_o, port3_bit_clock_oe, port3_rx_frame_clock_o;
  logic        port3_rx_frame_clock_oe, port3_tx_frame_clock_o, port3_tx_frame_clock_oe;
  logic        port3_rx_frame_sync, port3_tx_frame_sync, port3_async_domain, port3_family_44k;
  logic        idle_pat = 1'h0;
  logic        far_bclk, far_frame, pb;
  logic [1:0]  pf;
  int          cnt_f [2];
  int          len [2];
  int          n_errors = 0;
  int          cmp_count = 0;
  wire         far_en = !port2_master;
  wire         bc_in = far_en ? far_bclk : idle_pat;
  wire         fr_in = far_en ? far_frame : idle_pat;
  wire         port2_bit_clock_i = port2_bit_clock_oe ? port2_bit_clock_o : bc_in;
  wire         port2_rx_frame_clock_i = port2_rx_frame_clock_oe ? port2_rx_frame_clock_o : fr_in;
  wire         port2_tx_frame_clock_i = port2_tx_frame_clock_oe ? port2_tx_frame_clock_o : fr_in;
  wire         port3_bit_clock_i = port3_bit_clock_oe ? port3_bit_clock_o : bc_in;
  wire         port3_rx_frame_clock_i = port3_rx_frame_clock_oe ? port3_rx_frame_clock_o : fr_in;
  wire         port3_tx_frame_clock_i = port3_tx_frame_clock_oe ? port3_tx_frame_clock_o : fr_in;
  wire [1:0]   fsync = {port2_tx_frame_sync, port2_rx_frame_sync};

  abpf_top dut_u (.*);
  abpf_far_end far_u (
    .sys_clk (sys_clk),
    .en      (far_en),
    .div     (13'h0004),
    .bclk    (far_bclk),
    .frame   (far_frame)
  );

  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) idle_pat <= !idle_pat;

  // Counts bit-clock falls between frame rises on the rx and tx paths.
  always @(posedge sys_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (pb && !port2_bit_clock_i) cnt_f[i]++;
      if (!pf[i] && fsync[i]) begin
        len[i] = cnt_f[i];
        cnt_f[i] = 0;
      end
    end
    pb = port2_bit_clock_i;
    pf = fsync;
  end

  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_near(input int got, input int exp);
    cmp_count++;
    if (got < exp || got > exp + 2) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_near

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'h1;
    @(posedge sys_clk);
    reg_wr_en <= 1'h0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd_en <= 1'h1;
    @(posedge sys_clk);
    reg_rd_en <= 1'h0;
    @(posedge sys_clk);
    cmp(reg_rdata, exp);
  endtask : rd_chk

  // Waits for a bit-clock rise and returns the cycles spent.
  task automatic rise2(output int n);
    logic p;
    n = 0;
    p = 1'h1;
    while (n < 9000 && !(!p && port2_bit_clock_o)) begin
      p = port2_bit_clock_o;
      @(posedge sys_clk);
      n++;
    end
  endtask : rise2

  function automatic int f48(input int c);
    if (c == 18) return 24576000;
    return ((c % 2) ? 96000 : 64000) << ((c - 2) / 2);
  endfunction : f48

  task automatic fam(input logic [3:0] sel, input logic [4:0] ss, input logic [4:0] as,
                     input logic e44);
    int n;
    port2_rate_select <= sel;
    sys_sample_rate_setting <= ss;
    async_sample_rate_setting <= as;
    rise2(n);
    rise2(n);
    cmp_near(n, e44 ? 250000000 / 1881600 : 250000000 / 2048000);
    cmp(port2_family_44k, e44);
    cmp(port2_async_domain, sel[3]);
  endtask : fam

  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      rd_chk(RA[i], (i % 3 == 0) ? 16'h000c : 16'h0040);
    end
    for (int i = 0; i < 6; i++) begin
      wr(RA[i], 16'hffff);
      rd_chk(RA[i], (i % 3 == 0) ? 16'h001f : 16'h1fff);
    end
    wr(16'h0541, 16'h1234);
    rd_chk(16'h0541, 16'h0000);
  endtask : t_regs

  task automatic t_rates();
    int n;
    for (int c = 2; c <= 18; c++) begin
      wr(16'h0540, 16'(c));
      rise2(n);
      rise2(n);
      cmp_near(n, 250000000 / f48(c));
    end
    wr(16'h0540, 16'h000c);
    fam(4'h0, 5'h08, 5'h00, 1'h1);
    fam(4'h8, 5'h08, 5'h00, 1'h0);
    fam(4'h8, 5'h0f, 5'h0b, 1'h1);
    fam(4'h7, 5'h10, 5'h08, 1'h0);
  endtask : t_rates

  task automatic t_frames();
    wr(16'h0540, 16'h0012);
    wr(16'h0545, 16'h0005);
    wr(16'h0546, 16'h0003);
    port2_tx_frame_source_select <= 1'h1;
    port2_master <= 1'h0;
    @(posedge sys_clk);
    port2_master <= 1'h1;
    repeat (300) @(posedge sys_clk);
    cmp(len[0], 3);
    cmp(len[1], 5);
    cmp(port2_tx_frame_clock_oe, 1'h1);
    port2_tx_frame_source_select <= 1'h0;
    repeat (300) @(posedge sys_clk);
    cmp(len[1], 3);
  endtask : t_frames

  task automatic t_reserved();
    for (int i = 0; i < 3; i++) begin
      wr(16'h0540, (i < 2) ? 16'(i) : 16'h0013);
      repeat (3) @(posedge sys_clk);
      cmp({port3_bit_clock_oe, port2_bit_clock_oe, port2_bit_clock_o}, 3'h0);
    end
    wr(16'h0540, 16'h0002);
    repeat (3) @(posedge sys_clk);
    cmp(port2_bit_clock_oe, 1'h1);
  endtask : t_reserved

  task automatic t_slave();
    wr(16'h0540, 16'h0012);
    port2_master <= 1'h0;
    port3_master <= 1'h0;
    repeat (200) @(posedge sys_clk);
    cmp({port2_bit_clock_oe, port2_tx_frame_clock_oe, port3_tx_frame_clock_oe}, 3'h0);
    cmp(port3_async_domain, 1'h1);
    cmp(len[0], 4);
    cmp(len[1], 4);
  endtask : t_slave

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    t_regs();
    t_rates();
    t_frames();
    t_reserved();
    t_slave();
    tally_and_finish();
  end

  initial begin
    #300us;
    n_errors++;
    tally_and_finish();
  end
endmodule : test_audio_port_bit_frame_clock_gen
